// ### include/tsf_pkg.sv
// constants, register map and temperature helpers for the thermal status flags
package tsf_pkg;

   // apb address width and word index width
   localparam int unsigned APB_AW = 12;
   localparam int unsigned IDX_W  = 10;

   // register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_STATUS_TWO = 10'h003;
   localparam logic [IDX_W-1:0] IDX_CTRL       = 10'h010;
   localparam logic [IDX_W-1:0] IDX_SHUT_LIM   = 10'h011;
   localparam logic [IDX_W-1:0] IDX_PASSIVE    = 10'h012;
   localparam logic [IDX_W-1:0] IDX_LCRIT_LIM  = 10'h013;
   localparam logic [IDX_W-1:0] IDX_RCRIT_LIM  = 10'h014;
   localparam logic [IDX_W-1:0] IDX_LIVE       = 10'h015;

   // status two field positions, bits 2..0 are reserved
   localparam int unsigned BIT_OVERTEMP_IN = 7;
   localparam int unsigned BIT_LOCAL_SHUT  = 6;
   localparam int unsigned BIT_PASSIVE     = 5;
   localparam int unsigned BIT_LOCAL_CRIT  = 4;
   localparam int unsigned BIT_REMOTE_CRIT = 3;

   // control register fields
   localparam int unsigned BIT_OT_IRQ_EN      = 0;
   localparam int unsigned BIT_PASSIVE_IRQ_EN = 1;

   // live state register fields
   localparam int unsigned BIT_LIVE_PIN_LOW    = 0;
   localparam int unsigned BIT_LIVE_ARMED      = 1;
   localparam int unsigned BIT_LIVE_ALERT      = 2;
   localparam int unsigned BIT_LIVE_OVER_LIMIT = 3;

   // reset values
   localparam logic [7:0] STATUS_TWO_RST = 8'h00;
   localparam logic [7:0] CTRL_RST       = 8'h00;
   localparam logic [7:0] SHUT_LIM_RST   = 8'h50;
   localparam logic [7:0] PASSIVE_RST    = 8'h28;
   localparam logic [7:0] LCRIT_LIM_RST  = 8'h5A;
   localparam logic [7:0] RCRIT_LIM_RST  = 8'h5A;

   // shutdown re-arm hysteresis in degrees c
   localparam logic signed [8:0] HYST_DEGC = 9'sd5;
   // cycles the pin input is ignored after we stop driving it
   localparam logic [1:0] RELEASE_GUARD = 2'h3;

   // signed temperature strictly above a limit
   function automatic logic temp_gt(input logic [7:0] t, input logic [7:0] lim);
      temp_gt = $signed(t) > $signed(lim);
   endfunction

   // signed temperature at or above a limit
   function automatic logic temp_ge(input logic [7:0] t, input logic [7:0] lim);
      temp_ge = $signed(t) >= $signed(lim);
   endfunction

   // temperature at least the hysteresis below a limit, no wrap
   function automatic logic temp_cool(input logic [7:0] t, input logic [7:0] lim);
      temp_cool = ($signed({t[7], t}) + HYST_DEGC) <= $signed({lim[7], lim});
   endfunction

endpackage

// ### rtl/tsf_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module tsf_sync #(
   parameter logic RST_VAL = 1'b1 // idle level of the pin
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic ce,
   // pin in, synchronised level out
   input  wire logic d,
   output logic      q
);

   logic meta_q; // first stage, read only by the second stage

   // two stages, only the second stage looks at the first one
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end else if (ce) begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule
`default_nettype wire

// ### rtl/tsf_flag.sv
// one read-to-clear status flag evaluated on a strobe
`timescale 1ns/1ns
`default_nettype none
module tsf_flag #(
   parameter logic CLR_IDLE = 1'b1 // clear when the condition is false
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic ce,
   // evaluation strobe and condition
   input  wire logic eval,
   input  wire logic cond,
   // clear from a completed read that returned this flag
   input  wire logic clr,
   output logic      flag_q
);

   // setting beats clearing so an event at the read edge is kept
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else if (ce) begin
         if (eval && cond) begin
            flag_q <= 1'b1;
         end else if (clr || (eval && CLR_IDLE)) begin
            flag_q <= 1'b0;
         end
      end
   end

endmodule
`default_nettype wire

// ### rtl/tsf_top.sv
// second thermal status register with flag logic, pins and apb slave
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none

// How it works
// [R01] status two resets to all zeros
// [R02] bit 7 sets when pin pulled low
// [R03] pin seen low forces full fan speed
// [R04] read clears bit 7, resets if held
// [R05] bit 6 set when local above shutdown
// [R06] set bit 6 pulls overtemp pin low
// [R07] bit 6 alerts only if enabled
// [R08] bit 6 clears on status one read
// [R09] after clear, stays clear until 5C below
// [R10] bit 5 set at or below passive temp
// [R11] bit 5 alerts only if enabled
// [R12] read clears bit 5, sets again on next monitor tick if still at or below
// [R13] bit 4 set at local critical
// [R14] bit 4 pulls over-limit low, always alerts
// [R15] bit 3 set at remote critical
// [R16] bit 3 pulls over-limit low, always alerts
// [R17] read clears critical flags, reassert if persisting
// [R18] bits 2..0 always read zero
// [R19] clear only flags actually returned
module tsf_top
   import tsf_pkg::*;
(
   // clock, reset, clock enable
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // temperatures from the monitor, same clock
   input  wire logic              monitor_tick,
   input  wire logic [7:0]        local_temp,
   input  wire logic [7:0]        remote_temp,
   input  wire logic [7:0]        active_temp,
   // read strobe of the first status register
   input  wire logic              status_one_rd,
   // open-drain overtemp pin
   input  wire logic              overtemp_pin_in,
   output logic                   overtemp_pin_out,
   output logic                   overtemp_pin_oe,
   // active-low outputs and fan override
   output logic                   over_limit_pin_n,
   output logic                   smbalert_n,
   output logic                   fan_full_speed
);

   // software registers
   logic [7:0] ctrl_q;        // interrupt enables
   logic [7:0] shut_lim_q;    // local shutdown limit
   logic [7:0] passive_cooling_temp_q; // passive threshold
   logic [7:0] lcrit_lim_q;   // local critical limit
   logic [7:0] rcrit_lim_q;   // remote critical limit

   // flags of the status register
   logic overtemp_input_seen;  // bit 7
   logic local_shutdown_flag_q; // bit 6
   logic passive_cooling_flag; // bit 5
   logic local_critical_flag;  // bit 4
   logic remote_critical_flag; // bit 3
   logic shut_armed_q;         // shutdown may set again

   // pin sampling
   logic       pin_sync;       // synchronised pin level
   logic [1:0] guard_q;        // cycles to ignore after release
   logic       pin_low_seen;   // pulled low by someone else

   // apb decode
   logic [IDX_W-1:0] idx;     // word index
   logic             hit;     // mapped address
   logic             setup;   // setup phase, answer not yet armed
   logic             done;    // access completes this edge
   logic             wr_en;   // write takes effect
   logic             rd_two;  // completed read of status two
   logic [7:0]       rd_mux;  // read data of the addressed word
   logic [7:0]       status_two; // assembled status value
   logic [7:0]       clr_mask; // flags that were returned
   logic             alert;   // any enabled alert cause
   logic             over_limit; // any critical flag

   // ------------------------------------------------------------------
   // pin input
   // ------------------------------------------------------------------

   // the pin is asynchronous to ref_clk
   tsf_sync #(
      .RST_VAL (1'b1)
   ) u_pin_sync (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .d       (overtemp_pin_in),
      .q       (pin_sync)
   );

   // our own drive comes back through the synchroniser, so a low that
   // lingers after release must not count as an outside party
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         guard_q <= 2'h0;
      end else if (ce) begin
         if (overtemp_pin_oe) begin
            guard_q <= RELEASE_GUARD;
         end else if (guard_q != 2'h0) begin
            guard_q <= guard_q - 2'h1;
         end
      end
   end

   // low only counts while we are not driving it ourselves
   assign pin_low_seen = !pin_sync && !overtemp_pin_oe && (guard_q == 2'h0);

   // ------------------------------------------------------------------
   // status flags
   // ------------------------------------------------------------------

   // bit 7 is checked every cycle and only a read clears it
   tsf_flag #(
      .CLR_IDLE (1'b0)
   ) u_flag_pin (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .eval    (1'b1),
      .cond    (pin_low_seen),                  // [R02]
      .clr     (clr_mask[BIT_OVERTEMP_IN]),     // [R04]
      .flag_q  (overtemp_input_seen)
   );

   // bit 5 follows the active control temperature each monitor cycle
   tsf_flag #(
      .CLR_IDLE (1'b1)
   ) u_flag_passive (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .eval    (monitor_tick),
      .cond    (!temp_gt(active_temp, passive_cooling_temp_q)), // [R10]
      .clr     (clr_mask[BIT_PASSIVE]),         // [R12]
      .flag_q  (passive_cooling_flag)
   );

   // bit 4, local critical
   tsf_flag #(
      .CLR_IDLE (1'b1)
   ) u_flag_lcrit (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .eval    (monitor_tick),
      .cond    (temp_ge(local_temp, lcrit_lim_q)), // [R13]
      .clr     (clr_mask[BIT_LOCAL_CRIT]),      // [R17]
      .flag_q  (local_critical_flag)
   );

   // bit 3, remote critical
   tsf_flag #(
      .CLR_IDLE (1'b1)
   ) u_flag_rcrit (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .eval    (monitor_tick),
      .cond    (temp_ge(remote_temp, rcrit_lim_q)), // [R15]
      .clr     (clr_mask[BIT_REMOTE_CRIT]),     // [R17]
      .flag_q  (remote_critical_flag)
   );

   // bit 6, local shutdown; reading status two leaves it alone
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         local_shutdown_flag_q <= 1'b0; // [R01]
      end else if (ce) begin
         if (monitor_tick && shut_armed_q && !local_shutdown_flag_q
             && temp_gt(local_temp, shut_lim_q)) begin
            local_shutdown_flag_q <= 1'b1; // [R05]
         end else if (status_one_rd) begin
            local_shutdown_flag_q <= 1'b0; // [R08]
         end else if (monitor_tick && !temp_gt(local_temp, shut_lim_q)) begin
            local_shutdown_flag_q <= 1'b0; // [R05]
         end
      end
   end

   // once software clears it, a persisting hot state must not re-set it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         shut_armed_q <= 1'b1;
      end else if (ce) begin
         if (status_one_rd && local_shutdown_flag_q) begin
            shut_armed_q <= 1'b0; // [R09]
         end else if (monitor_tick && temp_cool(local_temp, shut_lim_q)) begin
            shut_armed_q <= 1'b1; // [R09]
         end
      end
   end

   // assembled value, reserved bits fixed at zero
   always_comb begin
      status_two                  = STATUS_TWO_RST; // [R01]
      status_two[BIT_OVERTEMP_IN] = overtemp_input_seen;
      status_two[BIT_LOCAL_SHUT]  = local_shutdown_flag_q;
      status_two[BIT_PASSIVE]     = passive_cooling_flag;
      status_two[BIT_LOCAL_CRIT]  = local_critical_flag;
      status_two[BIT_REMOTE_CRIT] = remote_critical_flag;
      status_two[2:0]             = 3'h0; // [R18]
   end

   // ------------------------------------------------------------------
   // pins and alert
   // ------------------------------------------------------------------

   // causes gathered for the alert line
   assign over_limit = local_critical_flag || remote_critical_flag; // [R14] [R16]
   assign alert = (local_shutdown_flag_q && ctrl_q[BIT_OT_IRQ_EN]) // [R07]
                || (passive_cooling_flag && ctrl_q[BIT_PASSIVE_IRQ_EN]) // [R11]
                || over_limit; // [R14] [R16]

   // every pin is registered, so each lags the flag or level it follows by one cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         overtemp_pin_out <= 1'b0;
         overtemp_pin_oe  <= 1'b0;
         over_limit_pin_n <= 1'b1;
         smbalert_n       <= 1'b1;
         fan_full_speed   <= 1'b0;
      end else if (ce) begin
         overtemp_pin_out <= 1'b0;                  // open drain only pulls low
         overtemp_pin_oe  <= local_shutdown_flag_q; // [R06]
         over_limit_pin_n <= !over_limit;           // [R14] [R16]
         smbalert_n       <= !alert;                // [R07] [R11]
         fan_full_speed   <= pin_low_seen;          // [R03]
      end
   end

   // ------------------------------------------------------------------
   // apb slave, no wait state, read data registered from a flop in the setup cycle
   // ------------------------------------------------------------------

   assign idx   = paddr[APB_AW-1:2];
   assign setup = psel && !penable && !pready;
   assign done  = psel && penable && pready;
   assign wr_en = done && pwrite && hit && pstrb[0];
   assign rd_two = done && !pwrite && hit && (idx == IDX_STATUS_TWO);

   // only what went out on prdata is cleared, later sets survive
   assign clr_mask = rd_two ? prdata[7:0] : 8'h00; // [R19]

   // address decode and read data of the addressed word
   always_comb begin
      hit    = (paddr[1:0] == 2'h0);
      rd_mux = 8'h00;
      case (idx)
         IDX_STATUS_TWO: rd_mux = status_two;
         IDX_CTRL:       rd_mux = ctrl_q;
         IDX_SHUT_LIM:   rd_mux = shut_lim_q;
         IDX_PASSIVE:    rd_mux = passive_cooling_temp_q;
         IDX_LCRIT_LIM:  rd_mux = lcrit_lim_q;
         IDX_RCRIT_LIM:  rd_mux = rcrit_lim_q;
         IDX_LIVE: begin
            rd_mux[BIT_LIVE_PIN_LOW] = pin_low_seen;
            rd_mux[BIT_LIVE_ARMED]   = shut_armed_q;
            rd_mux[BIT_LIVE_ALERT]   = !smbalert_n;
            rd_mux[BIT_LIVE_OVER_LIMIT] = !over_limit_pin_n;
         end
         default: hit = 1'b0; // unmapped word answers with an error
      endcase
   end

   // answer: ready one cycle after setup, then dropped at completion
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (ce) begin
         if (setup) begin
            pready  <= 1'b1;
            pslverr <= !hit;
            prdata  <= (hit && !pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
         end else if (done) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   // software registers, written at the completing edge only
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ctrl_q                 <= CTRL_RST;
         shut_lim_q             <= SHUT_LIM_RST;
         passive_cooling_temp_q <= PASSIVE_RST;
         lcrit_lim_q            <= LCRIT_LIM_RST;
         rcrit_lim_q            <= RCRIT_LIM_RST;
      end else if (ce && wr_en) begin
         case (idx)
            IDX_CTRL:      ctrl_q                 <= pwdata[7:0];
            IDX_SHUT_LIM:  shut_lim_q             <= pwdata[7:0];
            IDX_PASSIVE:   passive_cooling_temp_q <= pwdata[7:0];
            IDX_LCRIT_LIM: lcrit_lim_q            <= pwdata[7:0];
            IDX_RCRIT_LIM: rcrit_lim_q            <= pwdata[7:0];
            default: ; // status and live words are read only
         endcase
      end
   end

endmodule
`default_nettype wire

// ### bench/tsf_pin_model.sv
// far-side model of the open-drain overtemp pin with its pull-up
`timescale 1ns/1ns
`default_nettype none
module tsf_pin_model (
   // outside party pulling the line
   input  wire logic pull_low,
   // our block's pin driver
   input  wire logic drv_oe,
   input  wire logic drv_out,
   // resolved wire level
   output logic      pin_level
);
   // wired-and with pull-up: released line reads high, never the last value
   assign pin_level = !(pull_low || (drv_oe && !drv_out));
endmodule
`default_nettype wire

// ### bench/tsf_sva.sv
// port-level checker for the second thermal status register
`timescale 1ns/1ns
`default_nettype none
module tsf_sva
   import tsf_pkg::*;
(
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // apb side
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic [31:0]       prdata,
   input  wire logic              pready,
   input  wire logic              pslverr,
   // monitor and pins
   input  wire logic              monitor_tick,
   input  wire logic              status_one_rd,
   input  wire logic              overtemp_pin_in,
   input  wire logic              overtemp_pin_out,
   input  wire logic              overtemp_pin_oe,
   input  wire logic              over_limit_pin_n,
   input  wire logic              smbalert_n,
   input  wire logic              fan_full_speed
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // word index of the current address
   logic [IDX_W-1:0] idx;
   assign idx = paddr[APB_AW-1:2];
   // a setup cycle the slave will take
   sequence s_setup;
      psel && !penable && !pready && ce;
   endsequence
   // a status-one read with no evaluation in the same edge
   sequence s_status_one;
      status_one_rd && !monitor_tick;
   endsequence
   a_setup_answer: assert property (s_setup |=> pready)
      else $error("no answer one cycle after setup");
   a_slave_error: assert property (pready |-> pslverr == !(paddr[1:0] == 2'h0 &&
      (idx == IDX_STATUS_TWO || (idx >= IDX_CTRL && idx <= IDX_LIVE))))
      else $error("error response does not match address");
   a_reserved_zero: assert property (pready && !pwrite && paddr == 12'h00C |-> prdata[2:0] == 3'h0)
      else $error("reserved status bits read nonzero");
   a_pin_open_drain: assert property (overtemp_pin_oe |-> !overtemp_pin_out)
      else $error("overtemp pin driven high");
   a_crit_alert: assert property (!over_limit_pin_n |-> !smbalert_n)
      else $error("critical limit without alert");
   a_crit_tick: assert property ($fell(over_limit_pin_n) |-> $past(monitor_tick, 2))
      else $error("over-limit pin fell without evaluation");
   a_shut_tick: assert property ($rose(overtemp_pin_oe) |-> $past(monitor_tick, 2))
      else $error("overtemp drive rose without evaluation");
   a_shut_clear: assert property (s_status_one |=> ##1 !overtemp_pin_oe)
      else $error("shutdown flag kept after status one read");
   a_fan_rise: assert property ($rose(fan_full_speed) |-> !$past(overtemp_pin_in, 3))
      else $error("full fan speed without pin low");
   a_fan_release: assert property (overtemp_pin_in [*6] |=> !fan_full_speed)
      else $error("full fan speed after pin release");
endmodule
bind tsf_top tsf_sva u_sva (.ref_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
   .pslverr, .monitor_tick, .status_one_rd, .overtemp_pin_in, .overtemp_pin_out, .overtemp_pin_oe,
   .over_limit_pin_n, .smbalert_n, .fan_full_speed);
`default_nettype wire

// ### bench/tsf_top_test.sv
// register-level test of the second thermal status register
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tsf_top_test;
   import tsf_pkg::*;
   // stimulus and observed signals
   logic ref_clk, rst, ce, psel, penable, pwrite, monitor_tick, status_one_rd, pull_low;
   logic [APB_AW-1:0] paddr;
   logic [31:0]       pwdata, prdata;
   logic [3:0]        pstrb;
   logic [7:0]        local_temp, remote_temp, active_temp, rdv;
   logic              pready, pslverr, pin_in, pin_out, pin_oe, over_lim_n, alert_n, fan, erv;
   int                err_count, total_checks, i;
   // writable registers and their reset values
   logic [11:0] ra [5] = '{12'h040, 12'h044, 12'h048, 12'h04C, 12'h050};
   logic [7:0]  rv [5] = '{CTRL_RST, SHUT_LIM_RST, PASSIVE_RST, LCRIT_LIM_RST, RCRIT_LIM_RST};
   tsf_top u_tsf_top (.ref_clk(ref_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .monitor_tick(monitor_tick), .local_temp(local_temp), .remote_temp(remote_temp),
      .active_temp(active_temp), .status_one_rd(status_one_rd), .overtemp_pin_in(pin_in),
      .overtemp_pin_out(pin_out), .overtemp_pin_oe(pin_oe), .over_limit_pin_n(over_lim_n),
      .smbalert_n(alert_n), .fan_full_speed(fan));
   tsf_pin_model u_tsf_pin_model (.pull_low(pull_low), .drv_oe(pin_oe), .drv_out(pin_out), .pin_level(pin_in));
   // free-running clock, 4 ns period
   always #2 ref_clk = ~ref_clk;
   // one apb transfer; request held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] wd, output logic [7:0] rd,
                      output logic er);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h000000, wd};
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) err_count++;
      rd = prdata[7:0];
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // read a register and compare data with no error
   task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00, rdv, erv);
      `CHK({erv, rdv}, {1'b0, e})
   endtask
   // present temperatures on one monitoring cycle, return once the pins have settled
   task automatic tk(input logic [7:0] l, input logic [7:0] r, input logic [7:0] a);
      @(posedge ref_clk);
      local_temp   <= l;
      remote_temp  <= r;
      active_temp  <= a;
      monitor_tick <= 1'b1;
      @(posedge ref_clk);
      monitor_tick <= 1'b0;
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask
   // verdict and end of run
   task automatic test_done;
      if (err_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // watchdog against a hung handshake
   initial begin
      #40000;
      err_count++;
      test_done();
   end
   // main sequence
   initial begin
      ref_clk = 0; rst = 1; ce = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      pstrb = 4'hF; monitor_tick = 0; status_one_rd = 0; pull_low = 0;
      local_temp = 8'd25; remote_temp = 8'd25; active_temp = 8'd50;
      err_count = 0; total_checks = 0;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      rdchk(12'h00C, 8'h00);
      for (i = 0; i < 5; i++) rdchk(ra[i], rv[i]);
      apb(1'b1, 12'h00C, 8'hFF, rdv, erv);
      rdchk(12'h00C, 8'h00);
      apb(1'b0, 12'h0FC, 8'h00, rdv, erv);
      `CHK(erv, 1'b1)
      apb(1'b0, 12'h042, 8'h00, rdv, erv);
      `CHK(erv, 1'b1)
      // passive cooling at the boundary, then read clear and reassert
      tk(8'd25, 8'd25, 8'd40);
      `CHK(alert_n, 1'b1)
      rdchk(12'h00C, 8'h20);
      rdchk(12'h00C, 8'h00);
      tk(8'd25, 8'd25, 8'd40);
      rdchk(12'h00C, 8'h20);
      tk(8'd25, 8'd25, 8'd40);
      tk(8'd25, 8'd25, 8'd41);
      rdchk(12'h00C, 8'h00);
      apb(1'b1, 12'h040, 8'h02, rdv, erv);
      tk(8'd25, 8'd25, 8'd40);
      `CHK(alert_n, 1'b0)
      rdchk(12'h00C, 8'h20);
      repeat (2) @(negedge ref_clk);
      `CHK(alert_n, 1'b1)
      apb(1'b1, 12'h040, 8'h00, rdv, erv);
      // critical limits, shutdown limit moved out of the way
      apb(1'b1, 12'h044, 8'h7F, rdv, erv);
      tk(8'd90, 8'd89, 8'd50);
      `CHK({over_lim_n, alert_n}, 2'b00)
      rdchk(12'h00C, 8'h10);
      tk(8'd89, 8'd90, 8'd50);
      `CHK({over_lim_n, alert_n}, 2'b00)
      rdchk(12'h00C, 8'h08);
      tk(8'd89, 8'd90, 8'd50);
      rdchk(12'h00C, 8'h08);
      rdchk(12'h00C, 8'h00);
      repeat (2) @(negedge ref_clk);
      `CHK({over_lim_n, alert_n}, 2'b11)
      // local shutdown: strict compare, own drive ignored, status one clear and hysteresis
      apb(1'b1, 12'h044, 8'h50, rdv, erv);
      tk(8'd80, 8'd25, 8'd50);
      `CHK(pin_oe, 1'b0)
      tk(8'd81, 8'd25, 8'd50);
      `CHK({pin_oe, alert_n}, 2'b11)
      rdchk(12'h00C, 8'h40);
      rdchk(12'h00C, 8'h40);
      apb(1'b1, 12'h040, 8'h01, rdv, erv);
      repeat (2) @(negedge ref_clk);
      `CHK(alert_n, 1'b0)
      @(posedge ref_clk);
      status_one_rd <= 1'b1;
      @(posedge ref_clk);
      status_one_rd <= 1'b0;
      repeat (2) @(negedge ref_clk);
      `CHK(pin_oe, 1'b0)
      tk(8'd81, 8'd25, 8'd50);
      `CHK(pin_oe, 1'b0)
      tk(8'd76, 8'd25, 8'd50);
      tk(8'd81, 8'd25, 8'd50);
      `CHK(pin_oe, 1'b0)
      tk(8'd75, 8'd25, 8'd50);
      tk(8'd81, 8'd25, 8'd50);
      `CHK(pin_oe, 1'b1)
      tk(8'd25, 8'd25, 8'd50);
      `CHK(pin_oe, 1'b0)
      apb(1'b1, 12'h040, 8'h00, rdv, erv);
      // outside party holds the pin low, then lets go
      @(posedge ref_clk);
      pull_low <= 1'b1;
      repeat (8) @(negedge ref_clk);
      `CHK(fan, 1'b1)
      rdchk(12'h00C, 8'h80);
      rdchk(12'h00C, 8'h80);
      @(posedge ref_clk);
      pull_low <= 1'b0;
      repeat (8) @(negedge ref_clk);
      `CHK(fan, 1'b0)
      rdchk(12'h00C, 8'h80);
      rdchk(12'h00C, 8'h00);
      test_done();
   end
endmodule
`default_nettype wire
